/* testbench.sv */
// Self-checking bench: host byte tasks plus converter model.
// Assumes package, design and model are compiled first.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned P0 = 400;
	localparam int unsigned P1 = 200;
	localparam int unsigned P2 = 100;
	localparam int unsigned P3 = 50;
	logic REF_CLK = 1'b0;
	logic NRST = 1'b0;
	tsrl_pkg::tsrl_write_type HOST_WRITE = '0;
	logic HOST_READ_DONE = 1'b0;
	logic [7:0] READ_DATA;
	logic CONV_START;
	tsrl_pkg::tsrl_sample_type CONV_SAMPLE;
	logic CONV_BUSY;
	logic OVER_LIMIT;
	logic UNDER_LIMIT;
	logic [11:0] temp = 12'h190;
	int failures = 0;
	int samples_checked = 0;
	int cyc = 0;
	int starts = 0;
	int last = 0;
	int gap = 0;
	int unsigned per [4] = '{P0, P1, P2, P3};
	tsrl_register_logic #(.PERIOD_RATE0(P0), .PERIOD_RATE1(P1), .PERIOD_RATE2(P2),
		.PERIOD_RATE3(P3)) dut (.REF_CLK(REF_CLK), .NRST(NRST), .HOST_WRITE(HOST_WRITE),
		.HOST_READ_DONE(HOST_READ_DONE), .READ_DATA(READ_DATA), .CONV_START(CONV_START),
		.CONV_SAMPLE(CONV_SAMPLE), .CONV_BUSY(CONV_BUSY), .OVER_LIMIT(OVER_LIMIT),
		.UNDER_LIMIT(UNDER_LIMIT));
	tsrl_conv_model #(.DELAY(10)) conv (.clk(REF_CLK), .rst_n(NRST), .start(CONV_START),
		.temp(temp), .sample(CONV_SAMPLE));
	initial begin
		forever #4 REF_CLK = ~REF_CLK;
	end
	// =====================================================
	// Start spacing and timeout
	always @(posedge REF_CLK) begin
		cyc++;
		if (CONV_START === 1'b1) begin
			starts++;
			gap = cyc - last;
			last = cyc;
		end
		if (cyc > 20000) begin
			failures++;
			final_report();
		end
	end
	// =====================================================
	// Shared tasks
	task automatic tick(input int n);
		repeat (n) @(posedge REF_CLK);
		#1;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic is_sel, input logic [7:0] data);
		HOST_WRITE = {1'b1, is_sel, data};
		tick(1);
		HOST_WRITE = '0;
		tick(1);
	endtask
	task automatic rchk(input logic [7:0] sel, input logic [7:0] exp);
		wr(1'b1, sel);
		check({8'h00, READ_DATA}, {8'h00, exp});
		HOST_READ_DONE = 1'b1;
		tick(1);
		HOST_READ_DONE = 1'b0;
		tick(1);
	endtask
	task automatic shot(input logic [11:0] t, input logic [7:0] cfg);
		int n;
		int s;
		temp = t;
		s = starts;
		wr(1'b1, 8'h01);
		wr(1'b0, cfg);
		n = 0;
		while ((starts == s || CONV_BUSY !== 1'b0) && n < 100) begin
			tick(1);
			n++;
		end
		tick(2);
		check(16'(starts - s), 16'h0001);
	endtask
	task automatic final_report();
		$display("failures=%0d samples_checked=%0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// =====================================================
	// Scenarios
	task automatic t_reset();
		rchk(8'h00, 8'h00);
		rchk(8'h01, 8'h02);
		rchk(8'h03, 8'h3C);
		rchk(8'h02, 8'hF6);
	endtask
	task automatic t_shutdown();
		int s;
		wr(1'b1, 8'h01);
		wr(1'b0, 8'h00);
		tick(20);
		s = starts;
		tick(600);
		check(16'(starts - s), 16'h0000);
		rchk(8'h02, 8'hF6);
	endtask
	task automatic t_regs();
		wr(1'b1, 8'h02);
		wr(1'b0, 8'hA5);
		rchk(8'h02, 8'hA5);
		wr(1'b1, 8'h00);
		wr(1'b0, 8'hFF);
		rchk(8'h00, 8'h19);
		rchk(8'h05, 8'h00);
		wr(1'b1, 8'h02);
		wr(1'b0, 8'hF6);
	endtask
	task automatic t_shot();
		shot(12'h3DA, 8'h01);
		rchk(8'h01, 8'h10);
		rchk(8'h00, 8'h3D);
		rchk(8'h04, 8'hA0);
		shot(12'hF50, 8'h01);
		rchk(8'h01, 8'h08);
		shot(12'h000, 8'h01);
		rchk(8'h01, 8'h00);
	endtask
	task automatic t_latch();
		shot(12'h3DA, 8'h05);
		check({15'h0, OVER_LIMIT}, 16'h0001);
		shot(12'h000, 8'h05);
		check({15'h0, OVER_LIMIT}, 16'h0001);
		rchk(8'h01, 8'h14);
		check({14'h0, OVER_LIMIT, UNDER_LIMIT}, 16'h0000);
	endtask
	task automatic t_rate();
		int n;
		int s;
		for (int r = 0; r < 4; r++) begin
			wr(1'b1, 8'h01);
			wr(1'b0, {1'b0, 2'(r), 4'h1, 1'(r)});
			s = starts;
			n = 0;
			while (starts < s + 4 && n < 3000) begin
				tick(1);
				n++;
			end
			check(16'(gap), 16'(per[r]));
		end
		// Abort the running conversion; its late result must be ignored
		temp = 12'h7F0;
		wr(1'b0, 8'h00);
		tick(20);
		rchk(8'h00, 8'h00);
		check({14'h0, OVER_LIMIT, UNDER_LIMIT}, 16'h0000);
	endtask
	initial begin
		repeat (6) @(posedge REF_CLK);
		#1;
		NRST = 1'b1;
		t_reset();
		t_shutdown();
		t_regs();
		t_shot();
		t_latch();
		t_rate();
		final_report();
	end
endmodule // testbench

/* tsrl_conv_model.sv */
// Converter model: answers each start with one result after DELAY cycles.
// Assumes start is a one-cycle pulse on clk.
module tsrl_conv_model #(
	parameter int unsigned DELAY = 10
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Handshake
	input wire logic start,
	input wire logic [11:0] temp,
	output tsrl_pkg::tsrl_sample_type sample
);
	timeunit 1ns;
	timeprecision 1ns;
	int unsigned count;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= 0;
			sample <= '0;
		end else begin
			sample.done <= (count == 1);
			// Result is junk outside the done cycle
			sample.result <= (count == 1) ? temp : ~sample.result;
			if (start) begin
				count <= DELAY;
			end else if (count != 0) begin
				count <= count - 1;
			end
		end
	end
endmodule // tsrl_conv_model

/* tsrl_pkg.sv */
// Shared constants and types of the temperature sensor register logic.
// Assumes a single 125 MHz clock domain; users write tsrl_pkg::name.

package tsrl_pkg;

	// =====================================================================
	// Register selector codes
	localparam logic [2:0] TSRL_SEL_TEMP_HIGH = 3'h0;
	localparam logic [2:0] TSRL_SEL_CONFIG = 3'h1;
	localparam logic [2:0] TSRL_SEL_LOW_THR = 3'h2;
	localparam logic [2:0] TSRL_SEL_HIGH_THR = 3'h3;
	localparam logic [2:0] TSRL_SEL_TEMP_LOW = 3'h4;

	// =====================================================================
	// Reset values and fixed fields
	localparam logic [7:0] TSRL_CONFIG_RESET = 8'h02;
	localparam logic [7:0] TSRL_HIGH_THR_RESET = 8'h3C;
	localparam logic [7:0] TSRL_LOW_THR_RESET = 8'hF6;
	localparam logic [11:0] TSRL_RESULT_RESET = 12'h000;
	localparam logic [3:0] TSRL_LOW_BYTE_PAD = 4'h0;
	localparam logic [7:0] TSRL_UNMAPPED_READ = 8'h00;
	localparam logic TSRL_TOP_CONFIG_VALUE = 1'b0;

	// =====================================================================
	// Working modes
	localparam logic [1:0] TSRL_MODE_SHUTDOWN = 2'h0;
	localparam logic [1:0] TSRL_MODE_ONE_SHOT = 2'h1;

	// =====================================================================
	// Conversion periods, in ms, and their cycle counts
	localparam int unsigned TSRL_CLK_HZ = 125_000_000;
	localparam int unsigned TSRL_MS_PER_S = 1000;
	localparam int unsigned TSRL_PERIOD_RATE0_MS = 4000;
	localparam int unsigned TSRL_PERIOD_RATE1_MS = 1000;
	localparam int unsigned TSRL_PERIOD_RATE2_MS = 250;
	localparam int unsigned TSRL_PERIOD_RATE3_MS = 125;
	localparam int unsigned TSRL_CYCLES_PER_MS = TSRL_CLK_HZ / TSRL_MS_PER_S;
	localparam int unsigned TSRL_CYCLES_RATE0 = TSRL_PERIOD_RATE0_MS * TSRL_CYCLES_PER_MS;
	localparam int unsigned TSRL_CYCLES_RATE1 = TSRL_PERIOD_RATE1_MS * TSRL_CYCLES_PER_MS;
	localparam int unsigned TSRL_CYCLES_RATE2 = TSRL_PERIOD_RATE2_MS * TSRL_CYCLES_PER_MS;
	localparam int unsigned TSRL_CYCLES_RATE3 = TSRL_PERIOD_RATE3_MS * TSRL_CYCLES_PER_MS;

	// =====================================================================
	// Types
	typedef struct packed {
		logic top_config_bit;
		logic rate_select_upper;
		logic rate_select_lower;
		logic over_limit_flag;
		logic under_limit_flag;
		logic flag_latch_select;
		logic mode_select_upper;
		logic mode_select_lower;
	} tsrl_config_type;

	typedef struct packed {
		logic strobe;
		logic is_selector;
		logic [7:0] data;
	} tsrl_write_type;

	typedef struct packed {
		logic done;
		logic [11:0] result;
	} tsrl_sample_type;

	typedef enum logic [2:0] {
		TSRL_IDLE = 3'b001,
		TSRL_WAIT = 3'b010,
		TSRL_CONVERT = 3'b100
	} tsrl_state_type;

	// =====================================================================
	// Signed byte compare, one degree per count
	function automatic logic tsrl_above(input logic [7:0] a, input logic [7:0] b);
		return $signed(a) > $signed(b);
	endfunction

endpackage

/* tsrl_props.sv */
// Port checker for the temperature sensor register logic.
// Assumes one REF_CLK domain; bound to tsrl_register_logic below.
module tsrl_props (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic NRST,
	// Host side
	input wire tsrl_pkg::tsrl_write_type HOST_WRITE,
	input wire logic HOST_READ_DONE,
	input wire logic [7:0] READ_DATA,
	// Converter and status
	input wire logic CONV_START,
	input wire tsrl_pkg::tsrl_sample_type CONV_SAMPLE,
	input wire logic CONV_BUSY,
	input wire logic OVER_LIMIT,
	input wire logic UNDER_LIMIT
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] sel;
	logic [2:0] sel_d;
	logic latch;
	logic [1:0] mode_sh;
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!NRST);
	// =====================================================
	// Shadow of selector and latch control
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			sel <= 3'h0;
			sel_d <= 3'h0;
		end else begin
			sel_d <= sel;
			if (HOST_WRITE.strobe && HOST_WRITE.is_selector) begin
				sel <= HOST_WRITE.data[2:0];
			end
		end
	end
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			latch <= 1'b0;
			mode_sh <= 2'h2;
		end else if (HOST_WRITE.strobe && !HOST_WRITE.is_selector && sel == 3'h1) begin
			latch <= HOST_WRITE.data[2];
			mode_sh <= HOST_WRITE.data[1:0];
		end else if (CONV_BUSY && CONV_SAMPLE.done && mode_sh == 2'h1) begin
			mode_sh <= 2'h0;
		end
	end
	// =====================================================
	// Properties
	sequence s_pulse;
		CONV_START ##1 !CONV_START;
	endsequence
	sequence s_finish;
		CONV_BUSY && CONV_SAMPLE.done;
	endsequence
	start_busy_a: assert property (CONV_START |-> $rose(CONV_BUSY))
		else $error("start without busy rise");
	start_pulse_a: assert property (CONV_START |-> s_pulse)
		else $error("start longer than one cycle");
	busy_end_a: assert property (s_finish |=> !CONV_BUSY)
		else $error("busy after done");
	// A shutdown write may legally abort a running conversion
	busy_hold_a: assert property (CONV_BUSY && !CONV_SAMPLE.done && mode_sh != 2'h0 |=> CONV_BUSY)
		else $error("busy dropped early");
	idle_done_a: assert property (!CONV_BUSY && CONV_SAMPLE.done && !HOST_READ_DONE
		|=> $stable({OVER_LIMIT, UNDER_LIMIT}))
		else $error("flags moved on idle result");
	flag_view_a: assert property (sel == 3'h1 && sel_d == 3'h1
		|-> READ_DATA[4:3] == $past({OVER_LIMIT, UNDER_LIMIT}))
		else $error("config flags differ from ports");
	top_bit_a: assert property (sel == 3'h1 && sel_d == 3'h1 |-> !READ_DATA[7])
		else $error("config bit 7 not zero");
	low_pad_a: assert property (sel == 3'h4 && sel_d == 3'h4 |-> READ_DATA[3:0] == 4'h0)
		else $error("low byte pad not zero");
	unmapped_read_a: assert property (sel > 3'h4 && sel == sel_d |-> READ_DATA == 8'h00)
		else $error("unmapped read not zero");
	latch_clear_a: assert property (HOST_READ_DONE && sel == 3'h1 && latch && !CONV_SAMPLE.done
		|=> !OVER_LIMIT && !UNDER_LIMIT)
		else $error("latched flags not cleared");
endmodule // tsrl_props

bind tsrl_register_logic tsrl_props u_props (.REF_CLK(REF_CLK), .NRST(NRST),
	.HOST_WRITE(HOST_WRITE), .HOST_READ_DONE(HOST_READ_DONE), .READ_DATA(READ_DATA),
	.CONV_START(CONV_START), .CONV_SAMPLE(CONV_SAMPLE), .CONV_BUSY(CONV_BUSY),
	.OVER_LIMIT(OVER_LIMIT), .UNDER_LIMIT(UNDER_LIMIT));

/* tsrl_rate_timer.sv */
// Conversion pacing timebase: one-cycle tick at the selected rate.
// Assumes enable and rate come from registers on the same clock.

module tsrl_rate_timer #(
	parameter int unsigned PERIOD_RATE0 = tsrl_pkg::TSRL_CYCLES_RATE0,
	parameter int unsigned PERIOD_RATE1 = tsrl_pkg::TSRL_CYCLES_RATE1,
	parameter int unsigned PERIOD_RATE2 = tsrl_pkg::TSRL_CYCLES_RATE2,
	parameter int unsigned PERIOD_RATE3 = tsrl_pkg::TSRL_CYCLES_RATE3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic enable,
	input wire logic [1:0] rate,
	// Pacing pulse
	output logic tick
);

	logic [31:0] count;
	logic [31:0] limit;

	// =====================================================================
	// Period select
	always_comb begin
		case (rate)
			2'h0: limit = 32'(PERIOD_RATE0 - 1);
			2'h1: limit = 32'(PERIOD_RATE1 - 1);
			2'h2: limit = 32'(PERIOD_RATE2 - 1);
			2'h3: limit = 32'(PERIOD_RATE3 - 1);
			default: limit = 32'(PERIOD_RATE0 - 1);
		endcase
	end

	// =====================================================================
	// Counter; >= lets a rate change shorten the running period
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= 32'h0;
			tick <= 1'b0;
		end else if (!enable) begin
			count <= 32'h0;
			tick <= 1'b0;
		end else if (count >= limit) begin
			count <= 32'h0;
			tick <= 1'b1;
		end else begin
			count <= count + 32'h1;
			tick <= 1'b0;
		end
	end

endmodule // tsrl_rate_timer

/* tsrl_register_logic.sv */
// Register side of a serial-bus temperature sensor: selector, result,
// configuration, thresholds, limit flags and conversion sequencing.
// Assumes the bus engine and converter run on REF_CLK and hand over
// whole bytes and whole results, so no synchroniser is needed.

// What this block does
// - Selector codes 0..4 pick five registers.
// - High byte carries result bits 11..4.
// - Low byte carries bits 3..0, low nibble zero.
// - Configuration layout and reset value 0x02.
// - Rate field picks 0.25, 1, 4, 8 Hz.
// - Mode 00 shutdown, 01 one-shot, 1x continuous.
// - Shutdown stops conversions, registers stay accessible.
// - One-shot converts once, then returns to shutdown.
// - Continuous mode converts repeatedly at selected rate.
// - Over flag set when high byte exceeds threshold.
// - Under flag set when high byte below threshold.
// - Transparent flags follow each new result.
// - Latched flags hold until configuration read clears.
// - Thresholds reset to +60 and -10 degrees.
// - Thresholds are full eight-bit registers.
// - Writes commit only on complete bytes.
// - Temperature reads zero until first conversion.
// - Result is two's complement, 1/16 degree.
module tsrl_register_logic #(
	parameter int unsigned PERIOD_RATE0 = tsrl_pkg::TSRL_CYCLES_RATE0,
	parameter int unsigned PERIOD_RATE1 = tsrl_pkg::TSRL_CYCLES_RATE1,
	parameter int unsigned PERIOD_RATE2 = tsrl_pkg::TSRL_CYCLES_RATE2,
	parameter int unsigned PERIOD_RATE3 = tsrl_pkg::TSRL_CYCLES_RATE3
) (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic NRST,
	// Host byte port from the bus engine
	input wire tsrl_pkg::tsrl_write_type HOST_WRITE,
	input wire logic HOST_READ_DONE,
	output logic [7:0] READ_DATA,
	// Converter handshake
	output logic CONV_START,
	input wire tsrl_pkg::tsrl_sample_type CONV_SAMPLE,
	// Status
	output logic CONV_BUSY,
	output logic OVER_LIMIT,
	output logic UNDER_LIMIT
);

	tsrl_pkg::tsrl_state_type state;
	tsrl_pkg::tsrl_state_type next_state;
	logic [2:0] selector;
	logic [11:0] result;
	logic [7:0] low_thr;
	logic [7:0] high_thr;
	logic [1:0] rate;
	logic latch_sel;
	logic [1:0] mode;
	logic over_flag;
	logic under_flag;
	logic tick;
	logic data_write;
	logic config_write;
	logic sample_taken;
	logic latch_clear;
	logic eval_over;
	logic eval_under;
	logic [7:0] new_high_byte;
	tsrl_pkg::tsrl_config_type config_view;
	tsrl_pkg::tsrl_config_type config_in;

	// =====================================================================
	// Decode
	assign data_write = HOST_WRITE.strobe && !HOST_WRITE.is_selector;
	assign config_write = data_write && (selector == tsrl_pkg::TSRL_SEL_CONFIG);
	assign config_in = tsrl_pkg::tsrl_config_type'(HOST_WRITE.data);
	assign sample_taken = (state == tsrl_pkg::TSRL_CONVERT) && CONV_SAMPLE.done;
	assign latch_clear = HOST_READ_DONE && latch_sel
		&& (selector == tsrl_pkg::TSRL_SEL_CONFIG);
	assign new_high_byte = CONV_SAMPLE.result[11:4];
	assign eval_over = tsrl_pkg::tsrl_above(new_high_byte, high_thr);
	assign eval_under = tsrl_pkg::tsrl_above(low_thr, new_high_byte);

	// =====================================================================
	// Register selector; only the low bits are kept, upper bits are ignored
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			selector <= tsrl_pkg::TSRL_SEL_TEMP_HIGH;
		end else if (HOST_WRITE.strobe && HOST_WRITE.is_selector) begin
			selector <= HOST_WRITE.data[2:0];
		end
	end

	// =====================================================================
	// Thresholds
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			low_thr <= tsrl_pkg::TSRL_LOW_THR_RESET;
			high_thr <= tsrl_pkg::TSRL_HIGH_THR_RESET;
		end else if (data_write) begin
			if (selector == tsrl_pkg::TSRL_SEL_LOW_THR) begin
				low_thr <= HOST_WRITE.data;
			end
			if (selector == tsrl_pkg::TSRL_SEL_HIGH_THR) begin
				high_thr <= HOST_WRITE.data;
			end
		end
	end

	// =====================================================================
	// Configuration: rate and latch control
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			rate <= {tsrl_pkg::TSRL_CONFIG_RESET[6], tsrl_pkg::TSRL_CONFIG_RESET[5]};
			latch_sel <= tsrl_pkg::TSRL_CONFIG_RESET[2];
		end else if (config_write) begin
			rate <= {config_in.rate_select_upper, config_in.rate_select_lower};
			latch_sel <= config_in.flag_latch_select;
		end
	end

	// =====================================================================
	// Configuration: mode; a host write wins over the one-shot return
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			mode <= tsrl_pkg::TSRL_CONFIG_RESET[1:0];
		end else if (config_write) begin
			mode <= {config_in.mode_select_upper, config_in.mode_select_lower};
		end else if (sample_taken && mode == tsrl_pkg::TSRL_MODE_ONE_SHOT) begin
			mode <= tsrl_pkg::TSRL_MODE_SHUTDOWN;
		end
	end

	// =====================================================================
	// Conversion pacing
	tsrl_rate_timer #(
		.PERIOD_RATE0(PERIOD_RATE0),
		.PERIOD_RATE1(PERIOD_RATE1),
		.PERIOD_RATE2(PERIOD_RATE2),
		.PERIOD_RATE3(PERIOD_RATE3)
	) u_rate_timer (
		.clk(REF_CLK),
		.rst_n(NRST),
		.enable(mode[1]),
		.rate(rate),
		.tick(tick)
	);

	// =====================================================================
	// Sequencer
	always_comb begin
		next_state = state;
		case (state)
			tsrl_pkg::TSRL_IDLE: begin
				if (mode[1] || mode == tsrl_pkg::TSRL_MODE_ONE_SHOT) begin
					next_state = tsrl_pkg::TSRL_CONVERT;
				end
			end
			tsrl_pkg::TSRL_WAIT: begin
				if (mode == tsrl_pkg::TSRL_MODE_SHUTDOWN) begin
					next_state = tsrl_pkg::TSRL_IDLE;
				end else if (mode == tsrl_pkg::TSRL_MODE_ONE_SHOT || tick) begin
					next_state = tsrl_pkg::TSRL_CONVERT;
				end
			end
			tsrl_pkg::TSRL_CONVERT: begin
				if (mode == tsrl_pkg::TSRL_MODE_SHUTDOWN) begin
					next_state = tsrl_pkg::TSRL_IDLE;
				end else if (CONV_SAMPLE.done) begin
					next_state = mode[1] ? tsrl_pkg::TSRL_WAIT : tsrl_pkg::TSRL_IDLE;
				end
			end
			default: next_state = tsrl_pkg::TSRL_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			state <= tsrl_pkg::TSRL_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// =====================================================================
	// Converter start pulse, one cycle on entering conversion
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			CONV_START <= 1'b0;
		end else begin
			CONV_START <= (next_state == tsrl_pkg::TSRL_CONVERT)
				&& (state != tsrl_pkg::TSRL_CONVERT);
		end
	end

	assign CONV_BUSY = (state == tsrl_pkg::TSRL_CONVERT);

	// =====================================================================
	// Result capture, two's complement in 1/16 degree
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			result <= tsrl_pkg::TSRL_RESULT_RESET;
		end else if (sample_taken) begin
			result <= CONV_SAMPLE.result;
		end
	end

	// =====================================================================
	// Limit flags; a new result wins over a clearing read
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			over_flag <= tsrl_pkg::TSRL_CONFIG_RESET[4];
			under_flag <= tsrl_pkg::TSRL_CONFIG_RESET[3];
		end else if (sample_taken) begin
			if (latch_sel) begin
				over_flag <= (over_flag && !latch_clear) || eval_over;
				under_flag <= (under_flag && !latch_clear) || eval_under;
			end else begin
				over_flag <= eval_over;
				under_flag <= eval_under;
			end
		end else if (latch_clear) begin
			over_flag <= 1'b0;
			under_flag <= 1'b0;
		end
	end

	assign OVER_LIMIT = over_flag;
	assign UNDER_LIMIT = under_flag;

	// =====================================================================
	// Read data, one cycle behind the selector
	always_comb begin
		config_view.top_config_bit = tsrl_pkg::TSRL_TOP_CONFIG_VALUE;
		config_view.rate_select_upper = rate[1];
		config_view.rate_select_lower = rate[0];
		config_view.over_limit_flag = over_flag;
		config_view.under_limit_flag = under_flag;
		config_view.flag_latch_select = latch_sel;
		config_view.mode_select_upper = mode[1];
		config_view.mode_select_lower = mode[0];
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			READ_DATA <= tsrl_pkg::TSRL_UNMAPPED_READ;
		end else begin
			case (selector)
				tsrl_pkg::TSRL_SEL_TEMP_HIGH: READ_DATA <= result[11:4];
				tsrl_pkg::TSRL_SEL_CONFIG: READ_DATA <= 8'(config_view);
				tsrl_pkg::TSRL_SEL_LOW_THR: READ_DATA <= low_thr;
				tsrl_pkg::TSRL_SEL_HIGH_THR: READ_DATA <= high_thr;
				tsrl_pkg::TSRL_SEL_TEMP_LOW: READ_DATA <= {result[3:0], tsrl_pkg::TSRL_LOW_BYTE_PAD};
				default: READ_DATA <= tsrl_pkg::TSRL_UNMAPPED_READ;
			endcase
		end
	end

endmodule // tsrl_register_logic
